// [bench/i2cbr_bus_model.sv]
// open-drain bus model: pull-ups and a peripheral that can hold sda low
`timescale 1ns/1ps
`default_nettype none

module i2cbr_bus_model (
	input wire i2cbr_pkg::i2cbr_pin_out_t pin_out,
	input wire logic hold_sda,
	output var i2cbr_pkg::i2cbr_pin_in_t pin_in
);
	import i2cbr_pkg::*;
	// pull-up wins unless a party pulls the line low
	assign pin_in.scl_i = pin_out.scl_oe ? pin_out.scl_o : 1'b1;
	// peripheral stretch of sda, as an ack would
	assign pin_in.sda_i = hold_sda ? 1'b0 : (pin_out.sda_oe ? pin_out.sda_o : 1'b1);
endmodule

`default_nettype wire

// [bench/i2cbr_timing_tb.sv]
// self-checking testbench for the i2c bit-rate and hold-timing generator
`timescale 1ns/1ps
`default_nettype none

module i2cbr_timing_tb;
	import i2cbr_pkg::*;
	logic ref_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, hold_sda = 1'b0;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic cmd_ready, cmd_done;
	i2cbr_cmd_t cmd;
	i2cbr_pin_in_t pin_in;
	i2cbr_pin_out_t pin_out;
	int n_errors = 0, compares = 0, seed = 19;
	int cyc = 0, t_take = 0, t_sf = 0, t_sr = 0;
	logic rd_pend = 1'b0, scl_p = 1'b0, sda_p = 1'b0;
	logic [15:0] q_t[$], q_r[$]; // expected gaps, expected {mask, data}
	// settings: brd, divider, sda hold, start hold, stop hold
	logic [39:0] cfg [5] = '{40'h00_14_07_06_0b, 40'h47_28_0a_10_15, 40'h8b_28_09_10_15,
		40'hd4_50_11_22_29, 40'h65_f0_21_76_79};

	i2cbr_timing i2cbr_timing_inst (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd(cmd),
		.cmd_ready(cmd_ready), .cmd_done(cmd_done), .pin_in(pin_in), .pin_out(pin_out));
	i2cbr_bus_model i2cbr_bus_model_inst (.pin_out(pin_out), .hold_sda(hold_sda), .pin_in(pin_in));

	// 10 mhz clock
	always #50 ref_clk = ~ref_clk;

	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// one pin event against the oldest note; ffff means unchecked
	task automatic ev(input string nm, input int g);
		logic [15:0] e;
		if (q_t.size() == 0) begin
			n_errors++;
			$display("wrong value %s expected none seen %0d", nm, g);
		end else begin
			e = q_t.pop_front();
			if (e !== 16'hffff) check(nm, 16'(g), e);
		end
	endtask

	// one register cycle; a read notes its expected data
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] mk,
		input logic [7:0] e);
		@(posedge ref_clk);
		if (!w) q_r.push_back({mk, e});
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= w;
		reg_rd <= !w;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
	endtask

	// one command, driven for one cycle, then wait for done
	task automatic op(input i2cbr_cmd_t v);
		@(posedge ref_clk);
		cmd <= v;
		@(posedge ref_clk);
		cmd <= '0;
		t_take = cyc;
		@(negedge ref_clk);
		check("cmd ready busy", 16'(cmd_ready), 16'h0000);
		repeat (4000) begin
			@(negedge ref_clk);
			if (cmd_done === 1'b1) break;
		end
		check("cmd done", 16'(cmd_done), 16'h0001);
		check("cmd ready after", 16'(cmd_ready), 16'h0001);
	endtask

	// monitor: read data and gaps between pin events
	always @(negedge ref_clk) begin
		logic [15:0] e;
		cyc = cyc + 1;
		if (cyc > 60000) begin
			n_errors++;
			tally_and_finish();
		end
		if (rd_pend) begin
			e = q_r.pop_front();
			check("read data", {8'h00, reg_rdata & e[15:8]}, {8'h00, e[7:0] & e[15:8]});
		end else begin
			check("idle read data", {8'h00, reg_rdata}, 16'h0000);
		end
		rd_pend = reg_rd;
		if (pin_out.scl_oe && !scl_p) ev("scl low gap", cyc - (t_sf > t_sr ? t_sf : t_sr));
		if (!pin_out.scl_oe && scl_p) begin
			t_sr = cyc;
			ev("scl release gap", cyc - t_take);
		end
		if (pin_out.sda_oe && !sda_p) begin
			t_sf = cyc;
			ev("sda fall gap", cyc - t_take);
		end
		if (!pin_out.sda_oe && sda_p) ev("sda rise gap", pin_out.scl_oe ? cyc - t_take : cyc - t_sr);
		scl_p = pin_out.scl_oe;
		sda_p = pin_out.sda_oe;
	end

	// main sequence
	initial begin
		logic [39:0] c;
		int m, p;
		logic b, cur;
		cmd = '0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		bus(1'b0, ADDR_BRD, 8'h00, 8'hff, BRD_RESET);
		bus(1'b1, 8'h02, 8'($random(seed)), 8'h00, 8'h00); // unmapped write
		bus(1'b0, 8'h02, 8'h00, 8'hff, 8'h00);
		bus(1'b0, ADDR_BRD, 8'h00, 8'hff, BRD_RESET);
		for (int i = 0; i < 5; i++) begin
			c = cfg[i];
			m = (c[39:38] == 2'h1) ? 2 : (c[39:38] == 2'h2) ? 4 : 1;
			p = m * c[31:24];
			bus(1'b1, ADDR_BRD, c[39:32], 8'h00, 8'h00);
			bus(1'b0, ADDR_BRD, 8'h00, 8'hff, c[39:32]);
			bus(1'b0, ADDR_STAT, 8'h00, 8'h0f, {4'h0, c[39:38] == 2'h3, 3'h6});
			// start: sda low next cycle, scl low after the start hold
			q_t.push_back(16'h0001);
			q_t.push_back(16'(m * c[15:8]));
			op(4'h8);
			cur = 1'b1;
			// random bits, the last one low so the repeated start finds sda low
			for (int k = 0; k < 4; k++) begin
				b = (k == 3) ? 1'b0 : 1'($random(seed));
				if (!b != cur) q_t.push_back(16'(m * c[23:16] + 1));
				q_t.push_back(16'(p / 2 + 1));
				q_t.push_back(16'(p - p / 2));
				cur = !b;
				op({3'h2, b});
			end
			// repeated start: sda released after the hold, pulled low after the high half
			q_t.push_back(16'(m * c[23:16] + 1));
			q_t.push_back(16'(p / 2 + 1));
			q_t.push_back(16'(p + 1));
			q_t.push_back(16'(m * c[15:8]));
			op(4'h8);
			// stop: scl released at the half, sda rise after the stop hold
			q_t.push_back(16'(p / 2 + 1));
			q_t.push_back(16'(m * c[7:0]));
			op(4'h2);
		end
		// peripheral holds sda low; status shows the line level
		hold_sda <= 1'b1;
		repeat (4) @(posedge ref_clk);
		bus(1'b0, ADDR_STAT, 8'h00, 8'h07, 8'h02);
		repeat (4) @(posedge ref_clk);
		if (q_t.size() != 0 || q_r.size() != 0) n_errors++;
		tally_and_finish();
	end
endmodule

`default_nettype wire

// [hw/i2cbr_pkg.sv]
// package for the i2c bit-rate and hold-timing generator
package i2cbr_pkg;

	// register offsets on the plain register port
	localparam logic [7:0] ADDR_BRD = 8'h01;
	localparam logic [7:0] ADDR_STAT = 8'h03;
	localparam logic [7:0] BRD_RESET = 8'h00;

	// bit_rate_divider field positions
	localparam int FACT_HI = 7;
	localparam int FACT_LO = 6;
	localparam int RSEL_HI = 5;
	localparam int RSEL_LO = 0;

	// status register bit positions
	localparam int STAT_BUSY = 0;
	localparam int STAT_SCL = 1;
	localparam int STAT_SDA = 2;
	localparam int STAT_RSVD = 3;

	// rate_multiplier codes
	localparam logic [1:0] FACT_X1 = 2'h0;
	localparam logic [1:0] FACT_X2 = 2'h1;
	localparam logic [1:0] FACT_X4 = 2'h2;
	localparam logic [1:0] FACT_RSVD = 2'h3;

	// width of every bus-clock counter
	localparam int CNT_W = 10;

	// sequencer states and operations
	typedef enum logic [2:0] {ST_IDLE, ST_START_HOLD, ST_PARK, ST_LOW_HOLD, ST_LOW_REST,
		ST_HIGH, ST_STOP_HOLD} i2cbr_st_t;
	typedef enum logic [1:0] {OP_BIT, OP_STOP, OP_RSTART} i2cbr_op_t;

	// one lookup row: scl divider and three hold values
	typedef struct packed {
		logic [7:0] div;
		logic [6:0] sda;
		logic [6:0] start;
		logic [6:0] stop;
	} i2cbr_lut_t;

	// command group from the controller
	typedef struct packed {
		logic start;
		logic send_bit;
		logic stop;
		logic data;
	} i2cbr_cmd_t;

	// open-drain pin groups
	typedef struct packed {
		logic scl_i;
		logic sda_i;
	} i2cbr_pin_in_t;
	typedef struct packed {
		logic scl_o;
		logic scl_oe;
		logic sda_o;
		logic sda_oe;
	} i2cbr_pin_out_t;

	// whole state of the generator
	typedef struct packed {
		logic [7:0] brd;
		logic [7:0] rdata;
		logic [1:0] scl_s;
		logic [1:0] sda_s;
		i2cbr_st_t st;
		i2cbr_op_t op;
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] period_n;
		logic [CNT_W-1:0] sda_n;
		logic [CNT_W-1:0] rest_n;
		logic [CNT_W-1:0] high_n;
		logic [CNT_W-1:0] start_n;
		logic [CNT_W-1:0] stop_n;
		logic bitv;
		logic scl_oe;
		logic sda_oe;
		logic done;
	} i2cbr_state_t;

	// clock-rate select lookup; codes above 1f reuse row 1f
	function automatic i2cbr_lut_t i2cbr_lookup(input logic [5:0] sel);
		case (sel)
			6'h00: return '{8'h14, 7'h07, 7'h06, 7'h0b};
			6'h01: return '{8'h16, 7'h07, 7'h07, 7'h0c};
			6'h02: return '{8'h18, 7'h08, 7'h08, 7'h0d};
			6'h03: return '{8'h1a, 7'h08, 7'h09, 7'h0e};
			6'h04: return '{8'h1c, 7'h09, 7'h0a, 7'h0f};
			6'h05: return '{8'h1e, 7'h09, 7'h0b, 7'h10};
			6'h06: return '{8'h22, 7'h0a, 7'h0d, 7'h12};
			6'h07: return '{8'h28, 7'h0a, 7'h10, 7'h15};
			6'h08: return '{8'h1c, 7'h07, 7'h0a, 7'h0f};
			6'h09: return '{8'h20, 7'h07, 7'h0c, 7'h11};
			6'h0a: return '{8'h24, 7'h09, 7'h0e, 7'h13};
			6'h0b: return '{8'h28, 7'h09, 7'h10, 7'h15};
			6'h0c: return '{8'h2c, 7'h0b, 7'h12, 7'h17};
			6'h0d: return '{8'h30, 7'h0b, 7'h14, 7'h19};
			6'h0e: return '{8'h38, 7'h0d, 7'h18, 7'h1d};
			6'h0f: return '{8'h44, 7'h0d, 7'h1e, 7'h23};
			6'h10: return '{8'h30, 7'h09, 7'h12, 7'h19};
			6'h11: return '{8'h38, 7'h09, 7'h16, 7'h1d};
			6'h12: return '{8'h40, 7'h0d, 7'h1a, 7'h21};
			6'h13: return '{8'h48, 7'h0d, 7'h1e, 7'h25};
			6'h14: return '{8'h50, 7'h11, 7'h22, 7'h29};
			6'h15: return '{8'h58, 7'h11, 7'h26, 7'h2d};
			6'h16: return '{8'h68, 7'h15, 7'h2e, 7'h21};
			6'h17: return '{8'h80, 7'h15, 7'h3a, 7'h41};
			6'h18: return '{8'h50, 7'h09, 7'h26, 7'h29};
			6'h19: return '{8'h60, 7'h09, 7'h2e, 7'h31};
			6'h1a: return '{8'h70, 7'h11, 7'h36, 7'h39};
			6'h1b: return '{8'h80, 7'h11, 7'h3e, 7'h41};
			6'h1c: return '{8'h90, 7'h19, 7'h46, 7'h49};
			6'h1d: return '{8'ha0, 7'h19, 7'h4e, 7'h51};
			6'h1e: return '{8'hc0, 7'h21, 7'h5e, 7'h61};
			default: return '{8'hf0, 7'h21, 7'h76, 7'h79};
		endcase
	endfunction

endpackage

// [hw/i2cbr_timing.sv]
// i2c bit-rate and hold-timing generator with its register
`timescale 1ns/1ps
`default_nettype none

// Function
// - multiplier code gives factor 1, 2, 4
// - clock select picks divider and hold values
// - scl rate is bus clock over mul*divider
// - sda changes mul*sda_hold after scl falls
// - start: sda low, hold, then scl low
// - stop: scl high, hold, then sda high
module i2cbr_timing (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire i2cbr_pkg::i2cbr_cmd_t cmd,
	output logic cmd_ready,
	output logic cmd_done,
	input wire i2cbr_pkg::i2cbr_pin_in_t pin_in,
	output var i2cbr_pkg::i2cbr_pin_out_t pin_out
);
	import i2cbr_pkg::*;

	// reset image of the whole state
	localparam i2cbr_state_t RST_STATE = '{st: ST_IDLE, op: OP_BIT, brd: BRD_RESET,
		default: '0};

	i2cbr_state_t q; // registered state
	i2cbr_state_t d; // next state
	i2cbr_lut_t lut; // selected lookup row
	logic [1:0] mul_code; // rate_multiplier field
	logic [1:0] shift; // log2 of the factor
	logic [CNT_W-1:0] nx_period; // scaled scl period
	logic [CNT_W-1:0] nx_half; // low half of the period
	logic [CNT_W-1:0] nx_sda; // scaled sda hold
	logic [CNT_W-1:0] nx_rest; // rest of the low half
	logic [CNT_W-1:0] nx_high; // high half of the period
	logic [CNT_W-1:0] nx_start; // scaled start hold
	logic [CNT_W-1:0] nx_stop; // scaled stop hold
	logic busy; // a timed phase is running
	logic take; // a command is accepted

	// factor decode; reserved code runs as factor 1
	always_comb begin
		mul_code = q.brd[FACT_HI:FACT_LO];
		if (mul_code == FACT_X2) begin
			shift = 2'h1;
		end else if (mul_code == FACT_X4) begin
			shift = 2'h2;
		end else begin
			shift = 2'h0;
		end
	end

	// scaled counts from the selected row
	always_comb begin
		lut = i2cbr_lookup(q.brd[RSEL_HI:RSEL_LO]);
		nx_period = CNT_W'(lut.div) << shift;
		nx_half = nx_period >> 1;
		nx_high = nx_period - nx_half;
		nx_sda = CNT_W'(lut.sda) << shift;
		nx_start = CNT_W'(lut.start) << shift;
		nx_stop = CNT_W'(lut.stop) << shift;
		// keep the rest phase at least one cycle
		if (nx_half > nx_sda) begin
			nx_rest = nx_half - nx_sda;
		end else begin
			nx_rest = CNT_W'(1);
		end
	end

	// handshake toward the controller
	always_comb begin
		busy = (q.st != ST_IDLE) && (q.st != ST_PARK);
		cmd_ready = !busy;
		take = 1'b0;
		if (q.st == ST_IDLE) begin
			take = cmd.start;
		end else if (q.st == ST_PARK) begin
			take = cmd.start || cmd.stop || cmd.send_bit;
		end
	end

	// next state: registers, synchronisers, sequencer
	always_comb begin
		d = q;
		d.done = 1'b0;
		// two-flop synchronisers for the pins
		d.scl_s = {q.scl_s[0], pin_in.scl_i};
		d.sda_s = {q.sda_s[0], pin_in.sda_i};
		// register write
		if (reg_wr && (reg_addr == ADDR_BRD)) begin
			d.brd = reg_wdata;
		end
		// register read, data in the next cycle only
		d.rdata = 8'h00;
		if (reg_rd) begin
			if (reg_addr == ADDR_BRD) begin
				d.rdata = q.brd;
			end else if (reg_addr == ADDR_STAT) begin
				d.rdata[STAT_BUSY] = busy;
				d.rdata[STAT_SCL] = q.scl_s[1];
				d.rdata[STAT_SDA] = q.sda_s[1];
				d.rdata[STAT_RSVD] = (mul_code == FACT_RSVD);
			end else begin
				d.rdata = 8'h00;
			end
		end
		// settings latch only at a bit boundary
		if (take) begin
			d.period_n = nx_period;
			d.sda_n = nx_sda;
			d.rest_n = nx_rest;
			d.high_n = nx_high;
			d.start_n = nx_start;
			d.stop_n = nx_stop;
		end
		case (q.st)
			ST_IDLE: begin
				// bus free: only a start is taken
				if (cmd.start) begin
					d.sda_oe = 1'b1;
					d.scl_oe = 1'b0;
					d.st = ST_START_HOLD;
					d.cnt = nx_start - CNT_W'(1);
				end
			end
			ST_START_HOLD: begin
				// scl stays high for the start hold
				if (q.cnt == '0) begin
					d.scl_oe = 1'b1;
					d.st = ST_PARK;
					d.done = 1'b1;
				end else begin
					d.cnt = q.cnt - CNT_W'(1);
				end
			end
			ST_PARK: begin
				// scl held low; start beats stop beats bit
				if (cmd.start) begin
					d.op = OP_RSTART;
				end else if (cmd.stop) begin
					d.op = OP_STOP;
				end else begin
					d.op = OP_BIT;
				end
				d.bitv = cmd.data;
				if (take) begin
					d.st = ST_LOW_HOLD;
					d.cnt = nx_sda - CNT_W'(1);
				end
			end
			ST_LOW_HOLD: begin
				// sda untouched until the hold runs out
				if (q.cnt == '0) begin
					if (q.op == OP_BIT) begin
						d.sda_oe = !q.bitv;
					end else if (q.op == OP_STOP) begin
						d.sda_oe = 1'b1;
					end else begin
						d.sda_oe = 1'b0;
					end
					d.st = ST_LOW_REST;
					d.cnt = q.rest_n - CNT_W'(1);
				end else begin
					d.cnt = q.cnt - CNT_W'(1);
				end
			end
			ST_LOW_REST: begin
				// end of the low half: release scl
				if (q.cnt == '0) begin
					d.scl_oe = 1'b0;
					if (q.op == OP_STOP) begin
						d.st = ST_STOP_HOLD;
						d.cnt = q.stop_n - CNT_W'(1);
					end else begin
						d.st = ST_HIGH;
						d.cnt = q.high_n - CNT_W'(1);
					end
				end else begin
					d.cnt = q.cnt - CNT_W'(1);
				end
			end
			ST_HIGH: begin
				// end of the high half
				if (q.cnt == '0) begin
					if (q.op == OP_RSTART) begin
						// repeated start: sda falls with scl high
						d.sda_oe = 1'b1;
						d.st = ST_START_HOLD;
						d.cnt = q.start_n - CNT_W'(1);
					end else begin
						d.scl_oe = 1'b1;
						d.st = ST_PARK;
						d.done = 1'b1;
					end
				end else begin
					d.cnt = q.cnt - CNT_W'(1);
				end
			end
			ST_STOP_HOLD: begin
				// scl high; sda rises after the stop hold
				if (q.cnt == '0) begin
					d.sda_oe = 1'b0;
					d.st = ST_IDLE;
					d.done = 1'b1;
				end else begin
					d.cnt = q.cnt - CNT_W'(1);
				end
			end
			default: begin
				d.st = ST_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			q <= RST_STATE;
		end else begin
			q <= d;
		end
	end

	// outputs straight from flops; pins pull low only
	always_comb begin
		reg_rdata = q.rdata;
		cmd_done = q.done;
		pin_out.scl_o = 1'b0;
		pin_out.sda_o = 1'b0;
		pin_out.scl_oe = q.scl_oe;
		pin_out.sda_oe = q.sda_oe;
	end

	// helper: cycles spent in the current state
	logic [CNT_W-1:0] phase_q;
	// helper: cycles since the bit left park
	logic [CNT_W-1:0] bitlen_q;

	// helper counters for the checks
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			phase_q <= CNT_W'(1);
			bitlen_q <= '0;
		end else begin
			if (d.st != q.st) begin
				phase_q <= CNT_W'(1);
			end else begin
				phase_q <= phase_q + CNT_W'(1);
			end
			if ((q.st == ST_PARK) || (q.st == ST_IDLE)) begin
				bitlen_q <= '0;
			end else begin
				bitlen_q <= bitlen_q + CNT_W'(1);
			end
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	// last cycle of the low hold, start hold, stop hold and high phases
	sequence s_low_hold_end;
		(q.st == ST_LOW_HOLD) && (d.st != ST_LOW_HOLD);
	endsequence
	sequence s_start_end;
		(q.st == ST_START_HOLD) && (d.st != ST_START_HOLD);
	endsequence
	sequence s_stop_end;
		(q.st == ST_STOP_HOLD) && (d.st != ST_STOP_HOLD);
	endsequence
	sequence s_high_end;
		(q.st == ST_HIGH) && (d.st != ST_HIGH);
	endsequence

	// factor applied to the divider
	a_factor_scale:
	assert property (nx_period == CNT_W'(lut.div) * ((mul_code == FACT_X2) ? CNT_W'(2) :
		(mul_code == FACT_X4) ? CNT_W'(4) : CNT_W'(1)))
	else $error("scaled period does not follow the multiplier code");

	// lookup values taken on a start
	a_lookup_latch:
	assert property ((q.st == ST_IDLE) && cmd.start |=>
		(q.start_n == $past(nx_start)) && (q.stop_n == $past(nx_stop)) && (q.sda_n == $past(nx_sda)))
	else $error("lookup values not latched at start");

	// full bit lasts one scl period
	a_scl_period:
	assert property (s_high_end |-> (bitlen_q == q.period_n - CNT_W'(1)))
	else $error("scl period differs from factor times divider");

	// low hold lasts sda_n cycles with scl low, then the low rest follows
	a_sda_hold:
	assert property (s_low_hold_end |-> (phase_q == q.sda_n) && !q.scl_oe == 1'b0 ##1
		(q.st == ST_LOW_REST) && $stable(q.scl_oe))
	else $error("sda hold after scl fall is wrong");

	// sda untouched while the low hold counts down
	a_sda_hold_steady:
	assert property ((q.st == ST_LOW_HOLD) && (d.st == ST_LOW_HOLD) |=> $stable(q.sda_oe))
	else $error("sda moved inside the low hold");

	// start: sda low, scl high for the hold, then scl low
	a_start_hold:
	assert property (s_start_end |-> (phase_q == q.start_n) && q.sda_oe && !q.scl_oe ##1
		q.scl_oe && q.sda_oe)
	else $error("start hold is wrong");

	// stop: scl high for the hold, then sda released
	a_stop_hold:
	assert property (s_stop_end |-> (phase_q == q.stop_n) && q.sda_oe && !q.scl_oe ##1
		!q.sda_oe && !q.scl_oe && q.done)
	else $error("stop hold is wrong");

	// settings frozen while a phase runs
	a_settings_frozen:
	assert property (busy |=> $stable(q.period_n) && $stable(q.sda_n) && $stable(q.stop_n))
	else $error("timing settings changed inside a bit");

endmodule
`default_nettype wire
